//--- src/acc_regs.svh
// register offsets, field positions and reset values
`ifndef ACC_REGS_SVH
`define ACC_REGS_SVH

// ==========================================================================
// register offsets
`define ACC_CTRL_OFS      8'h00
`define ACC_MODE_OFS      8'h01
`define ACC_XIE_OFS       8'h02

// ==========================================================================
// control register fields
`define ACC_CTRL_EN_BIT   7
`define ACC_CTRL_OUT_BIT  6
`define ACC_CTRL_RIF_BIT  5
`define ACC_CTRL_FIF_BIT  4
`define ACC_CTRL_HYP_LSB  2
`define ACC_CTRL_HYN_LSB  0

// mode register fields
`define ACC_MODE_RIE_BIT  5
`define ACC_MODE_FIE_BIT  4
`define ACC_MODE_MD_LSB   0

// extended interrupt enable field
`define ACC_XIE_CMP_BIT   0

// ==========================================================================
// reset values
`define ACC_CTRL_RST      8'h00
`define ACC_MODE_RST      8'h02
`define ACC_XIE_RST       8'h00

`endif

//--- src/acc_pkg.sv
// types shared by the comparator control files
package acc_pkg;
  // hysteresis amount decoded from a two-bit field
  typedef enum logic [1:0] {
    ACC_HYS_OFF,
    ACC_HYS_SMALL,
    ACC_HYS_MEDIUM,
    ACC_HYS_LARGE
  } acc_hys_e;

  // settings delivered to the analog comparator
  typedef struct packed {
    logic       enable;
    logic [1:0] response_mode;
    acc_hys_e   pos_hys;
    acc_hys_e   neg_hys;
  } acc_analog_cfg_s;

  // register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } acc_bus_req_s;
endpackage

//--- src/acc_sync.sv
// three-stage synchroniser with agreement filter for a pin input
`timescale 1ns/1ps
module acc_sync (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_out <= 1'b0;
    end else if (s2_reg == s3_reg) begin
      sync_out <= s3_reg;
    end
  end
endmodule

//--- src/acc_top.sv
// comparator control wrapper: registers, edge flags, interrupt gating
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_top (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  input  wire acc_pkg::acc_bus_req_s  bus_req,
  output acc_pkg::acc_analog_cfg_s    analog_cfg,
  output logic [7:0]                  bus_rdata,
  input  wire logic                   comparator_raw,
  output logic                        comparator_irq
);
  import acc_pkg::*;

  // ========================================================================
  // register state
  logic       comparator_enable_bit_reg;
  logic [1:0] negative_hysteresis_field_reg;
  logic [1:0] positive_hysteresis_field_reg;
  logic [1:0] response_mode_field_reg;
  logic       rising_irq_enable_reg;
  logic       falling_irq_enable_reg;
  logic       xie_cmp_reg;
  logic       rising_edge_flag_reg;
  logic       falling_edge_flag_reg;
  logic       cmp_sync;
  logic       cmp_prev_reg;
  logic       cmp_valid_reg;
  logic       rise_evt;
  logic       fall_evt;
  logic       wr_ctrl;
  logic       wr_mode;
  logic       wr_xie;
  logic [7:0] rdata_next;

  // reset words as constants so the async reset branch loads constants only
  localparam logic [7:0] ctrl_reset = `ACC_CTRL_RST;
  localparam logic [7:0] mode_reset = `ACC_MODE_RST;
  localparam logic [7:0] xie_reset  = `ACC_XIE_RST;

  // ========================================================================
  // pin input crossing
  acc_sync u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in (comparator_raw),
    .sync_out (cmp_sync)
  );

  // ========================================================================
  // write decode
  always_comb begin
    wr_ctrl = 1'b0;
    wr_mode = 1'b0;
    wr_xie  = 1'b0;
    if (bus_req.wr && bus_req.addr == `ACC_CTRL_OFS) begin
      wr_ctrl = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `ACC_MODE_OFS) begin
      wr_mode = 1'b1;
    end else if (bus_req.wr && bus_req.addr == `ACC_XIE_OFS) begin
      wr_xie = 1'b1;
    end
  end

  // control register: enable and hysteresis fields
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_enable_bit_reg     <= ctrl_reset[`ACC_CTRL_EN_BIT];
      positive_hysteresis_field_reg <= ctrl_reset[`ACC_CTRL_HYP_LSB +: 2];
      negative_hysteresis_field_reg <= ctrl_reset[`ACC_CTRL_HYN_LSB +: 2];
    end else if (wr_ctrl) begin
      comparator_enable_bit_reg     <= bus_req.wdata[`ACC_CTRL_EN_BIT];
      positive_hysteresis_field_reg <=
        bus_req.wdata[`ACC_CTRL_HYP_LSB +: 2];
      negative_hysteresis_field_reg <=
        bus_req.wdata[`ACC_CTRL_HYN_LSB +: 2];
    end
  end

  // mode register: response time and edge enables
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      response_mode_field_reg <= mode_reset[`ACC_MODE_MD_LSB +: 2];
      rising_irq_enable_reg   <= mode_reset[`ACC_MODE_RIE_BIT];
      falling_irq_enable_reg  <= mode_reset[`ACC_MODE_FIE_BIT];
    end else if (wr_mode) begin
      response_mode_field_reg <= bus_req.wdata[`ACC_MODE_MD_LSB +: 2];
      rising_irq_enable_reg   <= bus_req.wdata[`ACC_MODE_RIE_BIT];
      falling_irq_enable_reg  <= bus_req.wdata[`ACC_MODE_FIE_BIT];
    end
  end

  // system-level comparator interrupt enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xie_cmp_reg <= xie_reset[`ACC_XIE_CMP_BIT];
    end else if (wr_xie) begin
      xie_cmp_reg <= bus_req.wdata[`ACC_XIE_CMP_BIT];
    end
  end

  // ========================================================================
  // analog settings, registered so the analog side sees clean levels
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_cfg <= '0;
    end else begin
      analog_cfg.enable        <= comparator_enable_bit_reg;
      analog_cfg.response_mode <= response_mode_field_reg;
      analog_cfg.pos_hys       <= acc_hys_e'(positive_hysteresis_field_reg);
      analog_cfg.neg_hys       <= acc_hys_e'(negative_hysteresis_field_reg);
    end
  end

  // ========================================================================
  // edge detection; while disabled the output is held low and no edges
  // count, the history restarts on enable so turn-on is not an edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_prev_reg  <= 1'b0;
      cmp_valid_reg <= 1'b0;
    end else begin
      cmp_prev_reg  <= cmp_sync;
      cmp_valid_reg <= comparator_enable_bit_reg;
    end
  end

  // output unsettled after power-up is the software's to wait out
  assign rise_evt = cmp_valid_reg && comparator_enable_bit_reg &&
                    cmp_sync && !cmp_prev_reg;
  assign fall_evt = cmp_valid_reg && comparator_enable_bit_reg &&
                    !cmp_sync && cmp_prev_reg;

  // sticky flags: a new edge wins over a clear in the same cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rising_edge_flag_reg  <= 1'b0;
      falling_edge_flag_reg <= 1'b0;
    end else begin
      if (rise_evt) begin
        rising_edge_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        rising_edge_flag_reg <= bus_req.wdata[`ACC_CTRL_RIF_BIT];
      end
      if (fall_evt) begin
        falling_edge_flag_reg <= 1'b1;
      end else if (wr_ctrl) begin
        falling_edge_flag_reg <= bus_req.wdata[`ACC_CTRL_FIF_BIT];
      end
    end
  end

  // ========================================================================
  // interrupt request: flag and edge enable, gated by system enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      comparator_irq <= 1'b0;
    end else begin
      comparator_irq <= xie_cmp_reg &&
        ((rising_edge_flag_reg && rising_irq_enable_reg) ||
         (falling_edge_flag_reg && falling_irq_enable_reg));
    end
  end

  // ========================================================================
  // read mux; unmapped addresses read as zero
  always_comb begin
    rdata_next = 8'h00;
    if (bus_req.addr == `ACC_CTRL_OFS) begin
      rdata_next[`ACC_CTRL_EN_BIT]       = comparator_enable_bit_reg;
      rdata_next[`ACC_CTRL_OUT_BIT]      = cmp_sync && comparator_enable_bit_reg;
      rdata_next[`ACC_CTRL_RIF_BIT]      = rising_edge_flag_reg;
      rdata_next[`ACC_CTRL_FIF_BIT]      = falling_edge_flag_reg;
      rdata_next[`ACC_CTRL_HYP_LSB +: 2] = positive_hysteresis_field_reg;
      rdata_next[`ACC_CTRL_HYN_LSB +: 2] = negative_hysteresis_field_reg;
    end else if (bus_req.addr == `ACC_MODE_OFS) begin
      rdata_next[`ACC_MODE_RIE_BIT]     = rising_irq_enable_reg;
      rdata_next[`ACC_MODE_FIE_BIT]     = falling_irq_enable_reg;
      rdata_next[`ACC_MODE_MD_LSB +: 2] = response_mode_field_reg;
    end else if (bus_req.addr == `ACC_XIE_OFS) begin
      rdata_next[`ACC_XIE_CMP_BIT] = xie_cmp_reg;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else if (bus_req.rd) begin
      bus_rdata <= rdata_next;
    end else begin
      bus_rdata <= 8'h00;
    end
  end
endmodule

//--- testbench/acc_top_monitor.sv
// checker on the comparator wrapper ports
`timescale 1ns/1ps
`include "acc_regs.svh"
module acc_top_monitor (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire acc_pkg::acc_bus_req_s    bus_req,
  input wire acc_pkg::acc_analog_cfg_s analog_cfg,
  input wire logic [7:0]               bus_rdata,
  input wire logic                     comparator_raw,
  input wire logic                     comparator_irq
);
  import acc_pkg::*;
  logic [3:0] mode_q, quiet_q;
  logic [4:0] cw;
  logic       xie_q, en_q, raw_q, wc, wm, rc, rm, ie_any;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // decoded strobes and the bits that reach the analog side
  assign wc = bus_req.wr && bus_req.addr == `ACC_CTRL_OFS;
  assign wm = bus_req.wr && bus_req.addr == `ACC_MODE_OFS;
  assign rc = bus_req.rd && bus_req.addr == `ACC_CTRL_OFS;
  assign rm = bus_req.rd && bus_req.addr == `ACC_MODE_OFS;
  assign cw = {bus_req.wdata[7], bus_req.wdata[3:0]};
  assign ie_any = mode_q[3] | mode_q[2];
  // shadow registers; quiet_q says the synchroniser holds no pending edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q  <= 4'h2;
      xie_q   <= 1'b0;
      en_q    <= 1'b0;
      raw_q   <= 1'b0;
      quiet_q <= 4'h0;
    end else begin
      if (wm) mode_q <= {bus_req.wdata[5:4], bus_req.wdata[1:0]};
      if (wc) en_q <= bus_req.wdata[7];
      if (bus_req.wr && bus_req.addr == `ACC_XIE_OFS) xie_q <= bus_req.wdata[0];
      raw_q   <= comparator_raw;
      if (raw_q != comparator_raw) quiet_q <= 4'h0;
      else if (quiet_q != 4'hF) quiet_q <= quiet_q + 4'h1;
    end
  end
  // ==========================================================
  // properties
  property p_mode;
    wm |-> ##2 analog_cfg.response_mode == $past(bus_req.wdata[1:0], 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode not applied");
  property p_ctrl;
    wc |-> ##2 {analog_cfg.enable, analog_cfg.pos_hys, analog_cfg.neg_hys} == $past(cw, 2);
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("ctrl not applied");
  property p_idle;
    !$past(bus_req.rd) |-> bus_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data not idle");
  property p_mdrd;
    rm |=> {bus_rdata[5:4], bus_rdata[1:0]} == $past(mode_q);
  endproperty
  a_mdrd: assert property (p_mdrd) else $error("mode readback");
  property p_off;
    rc && !en_q |=> bus_rdata[7:6] == 2'b00;
  endproperty
  a_off: assert property (p_off) else $error("output seen while off");
  property p_xie;
    comparator_irq |-> $past(xie_q);
  endproperty
  a_xie: assert property (p_xie) else $error("irq without system enable");
  property p_ie;
    comparator_irq |-> $past(ie_any);
  endproperty
  a_ie: assert property (p_ie) else $error("irq without edge enable");
  property p_clr;
    wc && bus_req.wdata[5:4] == 2'b00 && quiet_q >= 4'hA |-> ##2 !comparator_irq;
  endproperty
  a_clr: assert property (p_clr) else $error("irq after flags cleared");
  c_rise: cover property ($rose(comparator_irq));
  c_fall: cover property ($fell(comparator_irq));
  c_off: cover property (rc && !en_q);
endmodule

bind acc_top acc_top_monitor acc_top_monitor_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
  .analog_cfg(analog_cfg), .bus_rdata(bus_rdata),
  .comparator_raw(comparator_raw), .comparator_irq(comparator_irq));

//--- testbench/acc_pin_model.sv
// analog comparator stand-in driving the raw output pin
`timescale 1ns/1ps
module acc_pin_model (
  input wire logic                     sys_clk,
  input wire acc_pkg::acc_analog_cfg_s analog_cfg,
  input wire logic                     level_req,
  output logic                         comparator_raw
);
  import acc_pkg::*;
  logic [2:0] wait_q = 3'h0;
  initial comparator_raw = 1'b0;
  // unpowered output is garbage; slower modes settle one cycle later each
  always @(posedge sys_clk) begin
    if (!analog_cfg.enable) begin
      comparator_raw <= ~comparator_raw;
    end else if (comparator_raw == level_req) begin
      wait_q <= 3'h0;
    end else if (wait_q >= {1'b0, analog_cfg.response_mode}) begin
      comparator_raw <= level_req;
      wait_q <= 3'h0;
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the comparator control wrapper
`timescale 1ns/1ps
`include "acc_regs.svh"
module tb_top;
  import acc_pkg::*;
  localparam int   PWR_UP = 16; // software wait after enable, cycles
  logic            sys_clk = 1'b0;
  logic            rst_n = 1'b0;
  acc_bus_req_s    bus_req = '0;
  acc_analog_cfg_s analog_cfg;
  logic [7:0]      bus_rdata, got;
  logic            comparator_raw, comparator_irq;
  logic            level_req = 1'b0;
  logic [31:0]     seed = 32'h00016CB0;
  int              bad_count = 0;
  int              checks_done = 0;
  // ==========================================================
  // clock, device and analog pin model
  always #12.5 sys_clk = ~sys_clk;
  acc_top acc_top_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus_req(bus_req),
    .analog_cfg(analog_cfg), .bus_rdata(bus_rdata),
    .comparator_raw(comparator_raw), .comparator_irq(comparator_irq));
  acc_pin_model acc_pin_model_i (.sys_clk(sys_clk), .analog_cfg(analog_cfg),
    .level_req(level_req), .comparator_raw(comparator_raw));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  // request expected from flag pair, edge enables k[1:0], system enable k[2]
  function automatic logic irq_exp(input int k, input logic r, input logic f);
    return k[2] & ((r & k[1]) | (f & k[0]));
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // bus cycles: strobe for one cycle, read data taken the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge sys_clk);
    bus_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge sys_clk);
    bus_req.rd <= 1'b0;
    #1;
    got = bus_rdata;
  endtask
  // bounded waits: an expired bound is a mismatch and ends the run
  task automatic poll_out(input logic lvl);
    int n;
    got = {1'b0, ~lvl, 6'h00};
    for (n = 0; n < 40 && got[6] !== lvl; n++) rd(`ACC_CTRL_OFS);
    chk8({7'h00, got[6]}, {7'h00, lvl});
    if (n == 40) stop_test();
  endtask
  task automatic wait_irq(input logic e);
    int n;
    for (n = 0; n < 40 && comparator_irq !== e; n++) @(posedge sys_clk);
    chk8({7'h00, comparator_irq}, {7'h00, e});
    if (n == 40) stop_test();
  endtask
  initial begin
    int         i;
    logic [7:0] h;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`ACC_CTRL_OFS);
    chk8(got, `ACC_CTRL_RST);
    rd(`ACC_MODE_OFS);
    chk8(got & 8'h33, `ACC_MODE_RST);
    wr(8'h7F, 8'hFF);
    rd(8'h7F);
    chk8(got, 8'h00);
    $display("reset test done");
    // every response mode and hysteresis code, random edge enables
    for (i = 0; i < 4; i++) begin
      seed = xorshift(seed);
      h = {4'h8, i[1:0], ~i[1:0]};
      wr(`ACC_CTRL_OFS, h);
      wr(`ACC_MODE_OFS, {2'b00, seed[1:0], 2'b00, i[1:0]});
      rd(`ACC_CTRL_OFS);
      chk8(got & 8'h8F, h);
      chk8({analog_cfg.enable, 3'h0, analog_cfg.pos_hys, analog_cfg.neg_hys}, h);
      rd(`ACC_MODE_OFS);
      chk8(got & 8'h33, {2'b00, seed[1:0], 2'b00, i[1:0]});
      chk8({6'h00, analog_cfg.response_mode}, {6'h00, i[1:0]});
    end
    $display("settings test done");
    // both edges under all enable combinations, random hysteresis and speed
    for (i = 0; i < 8; i++) begin
      seed = xorshift(seed);
      h = {4'h0, seed[3:0]};
      wr(`ACC_XIE_OFS, {7'h00, i[2]});
      wr(`ACC_MODE_OFS, {2'b00, i[1:0], 2'b00, seed[5:4]});
      wr(`ACC_CTRL_OFS, h);
      level_req <= 1'b0;
      wr(`ACC_CTRL_OFS, h | 8'h80);
      repeat (PWR_UP) @(posedge sys_clk);
      wr(`ACC_CTRL_OFS, h | 8'h80);
      wait_irq(1'b0);
      level_req <= 1'b1;
      poll_out(1'b1);
      wait_irq(irq_exp(i, 1'b1, 1'b0));
      rd(`ACC_CTRL_OFS);
      chk8(got & 8'h70, 8'h60);
      @(posedge sys_clk);
      level_req <= 1'b0;
      poll_out(1'b0);
      wait_irq(irq_exp(i, 1'b1, 1'b1));
      rd(`ACC_CTRL_OFS);
      chk8(got & 8'h70, 8'h30);
      wr(`ACC_CTRL_OFS, h | 8'h80);
      wait_irq(1'b0);
    end
    wr(`ACC_CTRL_OFS, 8'h00);
    level_req <= 1'b1;
    repeat (20) @(posedge sys_clk);
    rd(`ACC_CTRL_OFS);
    chk8(got & 8'hF0, 8'h00);
    $display("edge test done");
    // mid-run reset after settings changed: registers return to reset values
    wr(`ACC_MODE_OFS, 8'h31);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(`ACC_CTRL_OFS);
    chk8(got, `ACC_CTRL_RST);
    rd(`ACC_MODE_OFS);
    chk8(got & 8'h33, `ACC_MODE_RST);
    rd(`ACC_XIE_OFS);
    chk8(got, `ACC_XIE_RST);
    $display("second reset test done");
    stop_test();
  end
endmodule
